// [src/i2c_monitor_timeout_status.sv]
/*
  Status flags of a two-wire bus controller: monitor ready, overrun,
  bus-active and went-idle flags, event and clock-low time-outs, an event
  log cleared by reading it, an interrupt mask and an AXI4-Lite slave.
  Assumes the bus lines come from pins in another clock domain and the
  monitored byte strobe comes from logic on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_monitor_timeout_status
  import i2c_status_pkg::*;
#(
  parameter int TO_W = 16
) (
  input  wire logic     ref_clk,
  input  wire logic     resetn,
  input  wire axiReq_t  busReq,
  output axiRsp_t       busRsp,
  input  wire logic     sclIn,
  input  wire logic     sdaIn,
  input  wire monByte_t monByte,
  output logic          monStretch,
  output logic          irq
);

  // ****************************************
  // Parameter check
  // ****************************************
  generate
    if (TO_W < 4 || TO_W > 32) begin : gBadWidth
      $error("TO_W must lie between 4 and 32");
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic            sclMeta;
    logic            sclSync;
    logic            sclPrev;
    logic            sdaMeta;
    logic            sdaSync;
    logic            sdaPrev;
    busState_t       busState;
    logic            monitor_data_ready_flag;
    logic [7:0]      monData;
    logic            monitor_overrun_flag;
    logic            wentIdle;
    logic            evTo;
    logic            sclTo;
    logic [TO_W-1:0] evCnt;
    logic [TO_W-1:0] lowCnt;
    logic [TO_W-1:0] timeout;
    logic            stretchEn;
    logic [31:0]     mask;
    logic [31:0]     evLog;
    logic            awHave;
    logic [31:0]     awAddr;
    logic            wHave;
    logic [31:0]     wData;
    logic [3:0]      wStrb;
    logic            bValid;
    logic [1:0]      bResp;
    logic            rValid;
    logic [31:0]     rData;
    logic [1:0]      rResp;
    logic            stretch;
    logic            irq;
  } state_t;

  state_t st_q;
  state_t st_d;

  // ****************************************
  // Helpers
  // ****************************************
  logic            startSeen;
  logic            stopSeen;
  logic            sclEdge;
  logic            busEvent;
  logic            evFire;
  logic            lowFire;
  logic            idleFire;
  logic            ovFire;
  logic            doWrite;
  logic            doRead;
  logic [31:0]     flagVec;
  logic [31:0]     wMask;
  logic [TO_W-1:0] cntMax;

  assign cntMax = '1;

  always_comb begin
    flagVec = '0;
    flagVec[MON_RDY_BIT] = st_q.monitor_data_ready_flag;
    flagVec[MON_OV_BIT] = st_q.monitor_overrun_flag;
    flagVec[MON_ACT_BIT] = (st_q.busState == BUS_ACTIVE);
    flagVec[MON_IDLE_BIT] = st_q.wentIdle;
    flagVec[EV_TO_BIT] = st_q.evTo;
    flagVec[SCL_TO_BIT] = st_q.sclTo;
  end

  // Byte-lane mask of the write in progress
  generate
    for (genvar lane = 0; lane < 4; lane++) begin : gLane
      assign wMask[lane*8 +: 8] = {8{st_q.wStrb[lane]}};
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;

    // Line synchronisers and edge finders
    st_d.sclMeta = sclIn;
    st_d.sclSync = st_q.sclMeta;
    st_d.sclPrev = st_q.sclSync;
    st_d.sdaMeta = sdaIn;
    st_d.sdaSync = st_q.sdaMeta;
    st_d.sdaPrev = st_q.sdaSync;
    startSeen = st_q.sclSync && st_q.sclPrev && st_q.sdaPrev && !st_q.sdaSync;
    stopSeen = st_q.sclSync && st_q.sclPrev && !st_q.sdaPrev && st_q.sdaSync;
    sclEdge = st_q.sclSync != st_q.sclPrev;
    busEvent = startSeen || stopSeen || sclEdge;

    // Bus activity
    idleFire = 1'b0;
    case (st_q.busState)
      BUS_IDLE: begin
        if (startSeen) begin
          st_d.busState = BUS_ACTIVE;
        end
      end
      BUS_ACTIVE: begin
        if (stopSeen) begin
          st_d.busState = BUS_IDLE;
          idleFire = 1'b1;
        end
      end
      default: begin
        st_d.busState = BUS_IDLE;
      end
    endcase

    // Event interval counter, held at zero while idle
    evFire = 1'b0;
    if (busEvent || st_q.busState == BUS_IDLE) begin
      st_d.evCnt = '0;
    end else begin
      evFire = (st_q.evCnt == st_q.timeout);
      if (st_q.evCnt != cntMax) begin
        st_d.evCnt = st_q.evCnt + 1'b1;
      end
    end

    // Clock-low counter
    lowFire = 1'b0;
    if (st_q.sclSync) begin
      st_d.lowCnt = '0;
    end else begin
      lowFire = (st_q.lowCnt == st_q.timeout);
      if (st_q.lowCnt != cntMax) begin
        st_d.lowCnt = st_q.lowCnt + 1'b1;
      end
    end

    // Monitor capture
    ovFire = monByte.valid && st_q.monitor_data_ready_flag && !st_q.stretchEn;
    doRead = busReq.arvalid && !st_q.rValid;
    doWrite = st_q.awHave && st_q.wHave && !st_q.bValid;

    if (doRead && busReq.araddr == RXDATA_ADDR) begin
      st_d.monitor_data_ready_flag = 1'b0;
    end
    if (monByte.valid && !ovFire) begin
      st_d.monData = monByte.data;
      st_d.monitor_data_ready_flag = 1'b1;
    end

    // Write channel capture, in either order
    if (busReq.awvalid && !st_q.awHave) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = busReq.awaddr;
    end
    if (busReq.wvalid && !st_q.wHave) begin
      st_d.wHave = 1'b1;
      st_d.wData = busReq.wdata;
      st_d.wStrb = busReq.wstrb;
    end

    // Register writes
    if (doWrite) begin
      st_d.awHave = 1'b0;
      st_d.wHave = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp = RESP_OKAY;
      case (st_q.awAddr)
        CFG_ADDR: begin
          if (st_q.wStrb[0]) begin
            st_d.stretchEn = st_q.wData[STRETCH_BIT];
          end
        end
        STATUS_ADDR: begin
          if (st_q.wStrb[LANE_LOW_FLAGS] && st_q.wData[MON_OV_BIT]) begin
            st_d.monitor_overrun_flag = 1'b0;
          end
          if (st_q.wStrb[LANE_LOW_FLAGS] && st_q.wData[MON_IDLE_BIT]) begin
            st_d.wentIdle = 1'b0;
          end
          if (st_q.wStrb[LANE_HIGH_FLAGS] && st_q.wData[EV_TO_BIT]) begin
            st_d.evTo = 1'b0;
          end
          if (st_q.wStrb[LANE_HIGH_FLAGS] && st_q.wData[SCL_TO_BIT]) begin
            st_d.sclTo = 1'b0;
          end
        end
        MASK_ADDR: begin
          st_d.mask = (st_q.mask & ~wMask) | (st_q.wData & wMask);
        end
        TIMEOUT_ADDR: begin
          st_d.timeout = TO_W'((32'(st_q.timeout) & ~wMask) | (st_q.wData & wMask));
        end
        EVLOG_ADDR, RXDATA_ADDR: begin
          st_d.bResp = RESP_OKAY;
        end
        default: begin
          st_d.bResp = RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bValid && busReq.bready) begin
      st_d.bValid = 1'b0;
    end

    // Register reads
    if (st_q.rValid && busReq.rready) begin
      st_d.rValid = 1'b0;
    end
    if (doRead) begin
      st_d.rValid = 1'b1;
      st_d.rResp = RESP_OKAY;
      case (busReq.araddr)
        CFG_ADDR: begin
          st_d.rData = READ_ZERO;
          st_d.rData[STRETCH_BIT] = st_q.stretchEn;
        end
        STATUS_ADDR: begin
          st_d.rData = flagVec;
        end
        MASK_ADDR: begin
          st_d.rData = st_q.mask;
        end
        EVLOG_ADDR: begin
          st_d.rData = st_q.evLog;
          st_d.evLog = '0;
        end
        TIMEOUT_ADDR: begin
          st_d.rData = 32'(st_q.timeout);
        end
        RXDATA_ADDR: begin
          st_d.rData = {24'h00_0000, st_q.monData};
        end
        default: begin
          st_d.rData = READ_ZERO;
          st_d.rResp = RESP_SLVERR;
        end
      endcase
    end

    // Hardware set wins over a clear in the same cycle
    if (ovFire) begin
      st_d.monitor_overrun_flag = 1'b1;
    end
    if (idleFire) begin
      st_d.wentIdle = 1'b1;
    end
    if (evFire) begin
      st_d.evTo = 1'b1;
    end
    if (lowFire) begin
      st_d.sclTo = 1'b1;
    end
    if (monByte.valid) begin
      st_d.evLog[MON_RDY_BIT] = 1'b1;
    end
    if (ovFire) begin
      st_d.evLog[MON_OV_BIT] = 1'b1;
    end
    if (idleFire) begin
      st_d.evLog[MON_IDLE_BIT] = 1'b1;
    end
    if (evFire) begin
      st_d.evLog[EV_TO_BIT] = 1'b1;
    end
    if (lowFire) begin
      st_d.evLog[SCL_TO_BIT] = 1'b1;
    end

    // Stretch request and interrupt
    st_d.stretch = st_d.monitor_data_ready_flag && st_d.stretchEn;
    st_d.irq = |(st_d.mask & (flagVec | st_d.evLog));
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.timeout <= TO_W'(TIMEOUT_RESET);
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign busRsp.awready = !st_q.awHave;
  assign busRsp.wready = !st_q.wHave;
  assign busRsp.bvalid = st_q.bValid;
  assign busRsp.bresp = st_q.bResp;
  assign busRsp.arready = !st_q.rValid;
  assign busRsp.rvalid = st_q.rValid;
  assign busRsp.rdata = st_q.rData;
  assign busRsp.rresp = st_q.rResp;
  assign monStretch = st_q.stretch;
  assign irq = st_q.irq;

endmodule

`default_nettype wire

// [src/i2c_status_pkg.sv]
/*
  Package for the two-wire bus monitor and time-out status block: register
  byte addresses, status field positions, bus state codes and the packed
  carriers of the AXI4-Lite slave port.
  Assumes a 32-bit AXI4-Lite master with 32-bit addresses.
*/
package i2c_status_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [31:0] CFG_ADDR    = 32'h4005_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h4005_0004;
  localparam logic [31:0] MASK_ADDR   = 32'h4005_0008;
  localparam logic [31:0] EVLOG_ADDR  = 32'h4005_000C;
  localparam logic [31:0] TIMEOUT_ADDR = 32'h4005_0010;
  localparam logic [31:0] RXDATA_ADDR = 32'h4005_0020;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int STRETCH_BIT   = 4;
  localparam int MON_RDY_BIT   = 16;
  localparam int MON_OV_BIT    = 17;
  localparam int MON_ACT_BIT   = 18;
  localparam int MON_IDLE_BIT  = 19;
  localparam int EV_TO_BIT     = 24;
  localparam int SCL_TO_BIT    = 25;
  localparam int LANE_LOW_FLAGS  = 2;
  localparam int LANE_HIGH_FLAGS = 3;

  // ****************************************
  // Reset values and answers
  // ****************************************
  localparam logic [31:0] TIMEOUT_RESET = 32'h0000_FFFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ACTIVE = 1'b1
  } busState_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axiReq_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axiRsp_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } monByte_t;

endpackage

// [verification/i2c_bus_model.sv]
/*
  Two-wire bus partner: drives the clock and data lines and the monitored
  byte strobe. Assumes the lines have pull-ups, so a released line is high.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_bus_model
  import i2c_status_pkg::*;
(
  input  wire logic ref_clk,
  output logic      scl,
  output logic      sda,
  output monByte_t  mb
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    mb  = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic start();
    @(posedge ref_clk) sda <= 1'b0;
    hold(8);
    scl <= 1'b0;
  endtask
  // Link clock of 150 ns only inside a frame
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk) scl <= 1'b1;
      hold(7);
      scl <= 1'b0;
      hold(7);
    end
  endtask
  task automatic stop();
    @(posedge ref_clk) scl <= 1'b1;
    hold(8);
    sda <= 1'b1;
    hold(8);
  endtask
  task automatic byteDone(input logic [7:0] d);
    @(posedge ref_clk) mb <= {d, 1'b1};
    @(posedge ref_clk) mb.valid <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [verification/i2c_monitor_timeout_status_checker.sv]
/*
  Port checker of the status block, bound to its top module.
  Assumes one clock domain, ref_clk, and reset resetn.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_monitor_timeout_status_checker
  import i2c_status_pkg::*;
#(
  parameter int TO_W = 16
) (
  input wire logic     ref_clk,
  input wire logic     resetn,
  input wire axiReq_t  busReq,
  input wire axiRsp_t  busRsp,
  input wire logic     sclIn,
  input wire logic     sdaIn,
  input wire monByte_t monByte,
  input wire logic     monStretch,
  input wire logic     irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rdStat_q;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) rdStat_q <= 1'b0;
    else if (busReq.arvalid && busRsp.arready) rdStat_q <= busReq.araddr == STATUS_ADDR;
  end
  sequence arTake;
    busReq.arvalid && busRsp.arready;
  endsequence
  aw_take_a: assert property (busReq.awvalid && busRsp.awready |=> !busRsp.awready)
    else $error("aw stays ready after take");
  b_hold_a: assert property (busRsp.bvalid && !busReq.bready |=> busRsp.bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (busRsp.rvalid && !busReq.rready |=> $stable(busRsp.rdata))
    else $error("read data changed early");
  r_lat_a: assert property (arTake |=> busRsp.rvalid)
    else $error("read answer late");
  ar_block_a: assert property (busRsp.rvalid |-> !busRsp.arready)
    else $error("ar taken while rvalid");
  rsvd_zero_a: assert property (busRsp.rvalid && rdStat_q |->
    busRsp.rdata[23:20] == 4'h0 && busRsp.rdata[31:26] == 6'h00)
    else $error("reserved status bits set");
  wr_order_a: assert property ($rose(busRsp.bvalid) |->
    $past(busRsp.awready) == 1'b0 && $past(busRsp.wready) == 1'b0)
    else $error("write answered before both taken");
  stretch_rise_a: assert property ($rose(monStretch) |-> $past(monByte.valid) ||
    $past(monByte.valid, 2) || busRsp.bvalid || $past(busRsp.bvalid))
    else $error("stretch without byte");
endmodule

bind i2c_monitor_timeout_status i2c_monitor_timeout_status_checker #(.TO_W(TO_W)) chk (
  .ref_clk(ref_clk), .resetn(resetn), .busReq(busReq), .busRsp(busRsp), .sclIn(sclIn),
  .sdaIn(sdaIn), .monByte(monByte), .monStretch(monStretch), .irq(irq));

`default_nettype wire

// [verification/i2c_monitor_timeout_status_tb.sv]
/*
  Testbench of the status block: AXI4-Lite tasks and bus scenarios.
  Assumes the partner model drives the bus lines and byte strobe.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_monitor_timeout_status_tb
  import i2c_status_pkg::*;
;
  logic     ref_clk;
  logic     resetn;
  axiReq_t  req;
  axiRsp_t  rsp;
  logic     scl;
  logic     sda;
  monByte_t mb;
  logic     monStretch;
  logic     irq;
  int       num_errors;
  int       compares;

  i2c_bus_model bm (.ref_clk(ref_clk), .scl(scl), .sda(sda), .mb(mb));
  i2c_monitor_timeout_status #(.TO_W(16)) dut (.ref_clk(ref_clk), .resetn(resetn),
    .busReq(req), .busRsp(rsp), .sclIn(scl), .sdaIn(sda), .monByte(mb),
    .monStretch(monStretch), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("num_errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    int n;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    b = 1'b0;
    n = 0;
    while (!b) begin
      @(negedge ref_clk);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      n++;
      if (n > 99) begin
        num_errors++;
        end_sim();
      end
      @(posedge ref_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
    end
  endtask
  task automatic rc(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    v = 1'b0;
    n = 0;
    while (!v) begin
      @(negedge ref_clk);
      ar = rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      n++;
      if (n > 99) begin
        num_errors++;
        end_sim();
      end
      @(posedge ref_clk);
      if (ar) req.arvalid <= 1'b0;
      if (v) req.rready <= 1'b0;
    end
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    num_errors = 0;
    compares = 0;
    resetn = 1'b0;
    req = '0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rc(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    rc(TIMEOUT_ADDR, TIMEOUT_RESET, RESP_OKAY);
    rc(32'h4005_0030, READ_ZERO, RESP_SLVERR);
    wr(TIMEOUT_ADDR, 32'h0000_0014, 4'hF);
    wr(MASK_ADDR, 32'h0008_0000, 4'hF);
    bm.start();
    rc(STATUS_ADDR, 32'h0004_0000, RESP_OKAY);
    bm.pulses(4);
    bm.hold(40);
    bm.stop();
    rc(STATUS_ADDR, 32'h0308_0000, RESP_OKAY);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(STATUS_ADDR, 32'h0300_0000, 4'hF);
    rc(STATUS_ADDR, 32'h0008_0000, RESP_OKAY);
    wr(STATUS_ADDR, 32'h0008_0000, 4'h4);
    rc(EVLOG_ADDR, 32'h0308_0000, RESP_OKAY);
    bm.hold(60);
    chk({31'h0, irq}, 32'h0000_0000);
    rc(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    bm.byteDone(8'hA5);
    rc(STATUS_ADDR, 32'h0001_0000, RESP_OKAY);
    bm.byteDone(8'h3C);
    rc(STATUS_ADDR, 32'h0003_0000, RESP_OKAY);
    rc(RXDATA_ADDR, 32'h0000_00A5, RESP_OKAY);
    rc(STATUS_ADDR, 32'h0002_0000, RESP_OKAY);
    wr(STATUS_ADDR, 32'h0000_0000, 4'hF);
    rc(STATUS_ADDR, 32'h0002_0000, RESP_OKAY);
    wr(STATUS_ADDR, 32'h0002_0000, 4'h4);
    rc(STATUS_ADDR, 32'h0000_0000, RESP_OKAY);
    wr(CFG_ADDR, 32'h0000_0010, 4'h1);
    bm.byteDone(8'h11);
    bm.hold(2);
    chk({31'h0, monStretch}, 32'h0000_0001);
    bm.byteDone(8'h22);
    rc(STATUS_ADDR, 32'h0001_0000, RESP_OKAY);
    rc(RXDATA_ADDR, 32'h0000_0022, RESP_OKAY);
    bm.hold(2);
    chk({31'h0, monStretch}, 32'h0000_0000);
    end_sim();
  end
endmodule

`default_nettype wire
